// File: src/flash_protect_pkg.sv
// Purpose: shared types and constants for the flash write-protection logic
// Assumes: one 125 MHz clock, 24-bit byte addresses
// Notes:   address bit 23 lies beyond the 8 MB array and is not decoded
package flash_protect_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 24;
  localparam int SECTOR_W      = 7;
  localparam int SUBSECTOR_W   = 11;
  localparam int SECTOR_LSB    = 16;
  localparam int SUBSECTOR_LSB = 12;
  localparam int SECTOR_COUNT  = 128;
  localparam int PAGE_BYTES    = 256;
  localparam int AREA_W        = 8;
  localparam int CODE_W        = 4;
  localparam int PULSE_W       = 16;
  localparam int BYTE_BITS_W   = 3;
  localparam logic [BYTE_BITS_W-1:0] BYTE_REMAINDER_NONE = 3'h0;
  localparam logic [AREA_W-1:0]      AREA_ONE            = 8'h01;
  localparam logic [AREA_W-1:0]      AREA_NONE           = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 125;
  localparam int POR_TIME_US = 100;
  localparam int POR_CYCLES  = POR_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE        = 4'h0,
    CMD_WRITE_EN    = 4'h1,
    CMD_WRITE_DIS   = 4'h2,
    CMD_PAGE_PROG   = 4'h3,
    CMD_SUBSEC_ERASE = 4'h4,
    CMD_SECTOR_ERASE = 4'h5,
    CMD_BULK_ERASE  = 4'h6,
    CMD_LOCK_WRITE  = 4'h7,
    CMD_STATUS_WRITE = 4'h8,
    CMD_CONFIG_WRITE = 4'h9
  } cmd_kind_t;

  typedef enum logic [1:0] {
    PWR_OFF   = 2'h0,
    PWR_WAIT  = 2'h1,
    PWR_READY = 2'h3
  } pwr_state_t;

  typedef struct packed {
    cmd_kind_t          kind;
    logic [ADDR_W-1:0]  addr;
    logic [PULSE_W-1:0] pulseCount;
    logic               lockDown;
    logic               writeLock;
  } cmd_req_t;

  typedef struct packed {
    logic                   allowed;
    logic                   notAligned;
    logic                   noWriteEnable;
    logic                   inPowerOn;
    logic                   areaProtected;
    logic                   sectorLocked;
    logic                   lockDownHeld;
    logic [SECTOR_W-1:0]    sector;
    logic [SUBSECTOR_W-1:0] subsector;
  } decision_t;

endpackage

// File: src/flash_write_protection.sv
// Purpose: decides whether a program, erase or register write may run
// Assumes: commands arrive decoded, one per cycle, on the ref_clk domain
// Notes:   lock bits are volatile and lost on reset or power loss
//
// How it works
// - sector is 64KB, holds sixteen 4KB subsectors
// - discard modifying command unless pulses byte-aligned
// - write enable sets latch; modify needs latch
// - power-on reset and timer block all writes
// - sector write-lock bit refuses program and erase
// - lock-down freezes write-lock until reset
// - lock bits change only by lock write, reset or power loss
// - low-end bit clear protects highest sectors
// - low-end bit set protects lowest sectors
// - code zero none; top bit all
// - 128 sectors; erase subsector, sector, or bulk
`timescale 1ns/1ps
module flash_write_protection #(
  parameter int PorCycles = flash_protect_pkg::POR_CYCLES
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset,
  input  wire logic                                 powerGood,
  input  wire logic                                 cmdValid,
  input  wire flash_protect_pkg::cmd_req_t          cmdReq,
  input  wire logic                                 protect_code_bit3,
  input  wire logic                                 protect_code_bit2,
  input  wire logic                                 protect_code_bit1,
  input  wire logic                                 protect_code_bit0,
  input  wire logic                                 protect_from_low_end,
  output logic                                      writeEnableLatch,
  output logic                                      powerOnBusy,
  output logic                                      decisionValid,
  output flash_protect_pkg::decision_t              decision
);
  import flash_protect_pkg::*;

  localparam int CNT_W = $clog2(PorCycles + 1);

  // ----------------------------------------------------------------
  // power-good pin synchroniser and filter
  // ----------------------------------------------------------------
  logic pgMeta;
  logic pgSync;
  logic pgLate;
  logic pgLevel;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pgMeta <= 1'b0;
      pgSync <= 1'b0;
      pgLate <= 1'b0;
    end else begin
      pgMeta <= powerGood;
      pgSync <= pgMeta;
      pgLate <= pgSync;
    end
  end

  // a change counts only once two later stages agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pgLevel <= 1'b0;
    end else if (pgSync == pgLate) begin
      pgLevel <= pgLate;
    end
  end

  // ----------------------------------------------------------------
  // power-on timer
  // ----------------------------------------------------------------
  pwr_state_t       pwrState;
  pwr_state_t       next_pwrState;
  logic [CNT_W-1:0] porCount;

  wire logic porDone = porCount == CNT_W'(PorCycles - 1);

  always_comb begin
    next_pwrState = pwrState;
    case (pwrState)
      PWR_OFF:   next_pwrState = pgLevel ? PWR_WAIT : PWR_OFF;
      PWR_WAIT:  next_pwrState = !pgLevel ? PWR_OFF : (porDone ? PWR_READY : PWR_WAIT);
      PWR_READY: next_pwrState = pgLevel ? PWR_READY : PWR_OFF;
      default:   next_pwrState = PWR_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwrState <= PWR_OFF;
      porCount <= '0;
    end else begin
      pwrState <= next_pwrState;
      porCount <= (pwrState == PWR_WAIT) ? porCount + CNT_W'(1) : '0;
    end
  end

  // blocks every write while supply or timer is not settled
  wire logic porBusy = pwrState != PWR_READY;
  assign powerOnBusy = porBusy;

  // ----------------------------------------------------------------
  // command classification and address decode
  // ----------------------------------------------------------------
  wire logic isArrayOp = (cmdReq.kind == CMD_PAGE_PROG)    ||
                         (cmdReq.kind == CMD_SUBSEC_ERASE) ||
                         (cmdReq.kind == CMD_SECTOR_ERASE) ||
                         (cmdReq.kind == CMD_BULK_ERASE);
  wire logic isLockWr  = cmdReq.kind == CMD_LOCK_WRITE;
  wire logic isRegWr   = isLockWr || (cmdReq.kind == CMD_STATUS_WRITE) ||
                         (cmdReq.kind == CMD_CONFIG_WRITE);
  wire logic isModify  = isArrayOp || isRegWr;
  wire logic isBulk    = cmdReq.kind == CMD_BULK_ERASE;

  wire logic [SECTOR_W-1:0]    secIdx = cmdReq.addr[SECTOR_LSB +: SECTOR_W];
  wire logic [SUBSECTOR_W-1:0] subIdx = cmdReq.addr[SUBSECTOR_LSB +: SUBSECTOR_W];

  wire logic aligned = cmdReq.pulseCount[BYTE_BITS_W-1:0] == BYTE_REMAINDER_NONE;

  // ----------------------------------------------------------------
  // area protection and sector locks
  // ----------------------------------------------------------------
  logic [SECTOR_COUNT-1:0] areaMap;
  logic [SECTOR_COUNT-1:0] writeLock;
  logic [SECTOR_COUNT-1:0] lockDown;

  sector_protect_map #(
    .SectorCount (SECTOR_COUNT)
  ) u_map (
    .protectCode       ({protect_code_bit3, protect_code_bit2,
                         protect_code_bit1, protect_code_bit0}),
    .protectFromLowEnd (protect_from_low_end),
    .sectorProtected   (areaMap)
  );

  // bulk erase targets every sector, so any hit refuses it
  wire logic areaHit = isBulk ? |areaMap : areaMap[secIdx];
  wire logic lockHit = isBulk ? |writeLock : writeLock[secIdx];
  wire logic downHit = lockDown[secIdx];

  wire logic refuseArray = isArrayOp && (areaHit || lockHit);
  wire logic refuseLock  = isLockWr && downHit;

  wire logic allowed = isModify && aligned && writeEnableLatch && !porBusy &&
                       !refuseArray && !refuseLock;
  wire logic lockTake = cmdValid && isLockWr && allowed;

  genvar s;
  generate
    for (s = 0; s < SECTOR_COUNT; s++) begin : g_lock
      wire logic hitHere = lockTake && (secIdx == SECTOR_W'(s));
      always_ff @(posedge ref_clk) begin
        if (reset || porBusy) begin
          writeLock[s] <= 1'b0;
          lockDown[s]  <= 1'b0;
        end else if (hitHere) begin
          writeLock[s] <= cmdReq.writeLock;
          lockDown[s]  <= cmdReq.lockDown;
        end
      end
      chk_down_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        lockDown[s] && !porBusy |=> lockDown[s])
        else $error("lock-down bit fell without reset");
    end
  endgenerate

  // ----------------------------------------------------------------
  // write enable latch
  // ----------------------------------------------------------------
  wire logic welSet   = cmdValid && aligned && (cmdReq.kind == CMD_WRITE_EN);
  wire logic welClear = cmdValid && aligned && (cmdReq.kind == CMD_WRITE_DIS);
  wire logic welUsed  = cmdValid && allowed;

  // a granted write consumes the latch so each one needs a fresh enable
  always_ff @(posedge ref_clk) begin
    if (reset || porBusy) begin
      writeEnableLatch <= 1'b0;
    end else if (welSet) begin
      writeEnableLatch <= 1'b1;
    end else if (welClear || welUsed) begin
      writeEnableLatch <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // decision register
  // ----------------------------------------------------------------
  // reasons and indices stand until the next answer; allowed pulses with it
  wire logic answerTake = cmdValid && isModify;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      decisionValid <= 1'b0;
      decision      <= '0;
    end else begin
      decisionValid          <= answerTake;
      decision.allowed       <= cmdValid && allowed;
      if (answerTake) begin
        decision.notAligned    <= !aligned;
        decision.noWriteEnable <= !writeEnableLatch;
        decision.inPowerOn     <= porBusy;
        decision.areaProtected <= isArrayOp && areaHit;
        decision.sectorLocked  <= isArrayOp && lockHit;
        decision.lockDownHeld  <= isLockWr && downHit;
        decision.sector        <= secIdx;
        decision.subsector     <= subIdx;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  wire logic [CODE_W-1:0] codeNow = {protect_code_bit3, protect_code_bit2,
                                     protect_code_bit1, protect_code_bit0};

  chk_sector_decode: assert property (cmdValid && isModify |=> decisionValid &&
    decision.sector == $past(cmdReq.addr[22:16]) &&
    decision.subsector == $past(cmdReq.addr[22:12]))
    else $error("sector index does not follow address");
  chk_byte_count: assert property (cmdValid && !aligned |=> !decision.allowed)
    else $error("unaligned command granted");
  chk_latch_needed: assert property (cmdValid && !writeEnableLatch |=> !decision.allowed)
    else $error("write granted without enable latch");
  chk_latch_sets: assert property (welSet && !porBusy |=> writeEnableLatch)
    else $error("enable latch not set");
  chk_por_blocks: assert property (cmdValid && porBusy |=> !decision.allowed && !writeEnableLatch)
    else $error("write granted during power-on");
  chk_lock_refuses: assert property (cmdValid && isArrayOp && lockHit |=> !decision.allowed &&
    decision.sectorLocked)
    else $error("locked sector written");
  chk_lockdown_freeze: assert property (!$past(porBusy) && !$past(reset) |->
    (($past(lockDown) & ~lockDown) == '0) &&
    ((($past(writeLock) ^ writeLock) & $past(lockDown)) == '0))
    else $error("frozen lock state changed");
  chk_lock_only_cmd: assert property (!lockTake && !porBusy |=> $stable(writeLock) &&
    $stable(lockDown))
    else $error("lock bits changed without lock write");
  chk_upper_half: assert property (!protect_from_low_end && codeNow == 4'h7 |->
    areaMap[63:0] == '0 && &areaMap[127:64])
    else $error("upper half map wrong");
  chk_lower_half: assert property (protect_from_low_end && codeNow == 4'h7 |->
    &areaMap[63:0] && areaMap[127:64] == '0)
    else $error("lower half map wrong");
  chk_code_extremes: assert property ((codeNow == 4'h0 |-> areaMap == '0) and
    (codeNow[3] |-> &areaMap))
    else $error("none or all map wrong");
  chk_bulk_scope: assert property (cmdValid && isBulk && (|areaMap || |writeLock) |=>
    !decision.allowed)
    else $error("bulk erase over protected sector");
  chk_area_refuses: assert property (cmdValid && isArrayOp && areaHit |=> !decision.allowed &&
    decision.areaProtected)
    else $error("protected area written");

  // ----------------------------------------------------------------
  // checks on latch, power-on and lock updates
  // ----------------------------------------------------------------
  chk_latch_clears: assert property (cmdValid && allowed |=>
    !writeEnableLatch)
    else $error("enable latch kept after granted write");
  chk_por_clears_locks: assert property (porBusy |=>
    writeLock == '0 && lockDown == '0 && !writeEnableLatch)
    else $error("volatile state kept during power-on");
  chk_por_follows_supply: assert property (!pgLevel |=>
    porBusy)
    else $error("power-on busy dropped without supply");
  chk_por_timer_runs: assert property (pwrState == PWR_WAIT && !porDone |=>
    porBusy)
    else $error("power-on timer ended early");
  chk_lock_write_lands: assert property (lockTake |=>
    writeLock[$past(secIdx)] == $past(cmdReq.writeLock) &&
    lockDown[$past(secIdx)] == $past(cmdReq.lockDown))
    else $error("lock write did not land");
  chk_lockdown_refuses: assert property (cmdValid && isLockWr && downHit |=>
    !decision.allowed && decision.lockDownHeld)
    else $error("lock write granted on locked-down sector");

  // ----------------------------------------------------------------
  // checks on grants and answer fields
  // ----------------------------------------------------------------
  chk_grant_when_clear: assert property (cmdValid && isArrayOp && aligned &&
    writeEnableLatch && !porBusy && !areaHit && !lockHit |=> decision.allowed)
    else $error("clear array command refused");
  chk_reg_write_grant: assert property (cmdValid && isRegWr && !isLockWr && aligned &&
    writeEnableLatch && !porBusy |=> decision.allowed)
    else $error("clear register write refused");
  chk_subsector_nests: assert property (decisionValid |->
    decision.subsector[SUBSECTOR_W-1 -: SECTOR_W] == decision.sector)
    else $error("subsector outside its sector");
  chk_fields_hold: assert property (!answerTake |=> $stable(decision.sector) &&
    $stable(decision.subsector) && $stable(decision.areaProtected))
    else $error("answer fields moved without a command");

  cov_program_granted: cover property (cmdValid && cmdReq.kind == CMD_PAGE_PROG ##1
    decision.allowed);
  cov_lock_written: cover property (lockTake ##1 |writeLock);
  cov_area_refused: cover property (cmdValid && isArrayOp && areaHit && writeEnableLatch);
  cov_lockdown_refused: cover property (cmdValid && refuseLock && writeEnableLatch);
  cov_lockdown_set: cover property (lockTake && cmdReq.lockDown ##1
    |lockDown);

endmodule

// File: src/sector_protect_map.sv
// Purpose: expands the protect code into one protected flag per sector
// Assumes: code bit 3 set protects the whole array
// Notes:   purely combinational
`timescale 1ns/1ps
module sector_protect_map #(
  parameter int SectorCount = flash_protect_pkg::SECTOR_COUNT
) (
  input  wire logic [flash_protect_pkg::CODE_W-1:0] protectCode,
  input  wire logic                                 protectFromLowEnd,
  output logic [SectorCount-1:0]                    sectorProtected
);
  import flash_protect_pkg::*;

  // ----------------------------------------------------------------
  // size of the protected area in sectors
  // ----------------------------------------------------------------
  wire logic [2:0]        areaCode = protectCode[2:0];
  wire logic [AREA_W-1:0] areaSize = (areaCode == 3'h0) ? AREA_NONE :
                                     (AREA_ONE << (areaCode - 3'h1));
  wire logic [AREA_W-1:0] upperStart = AREA_W'(SectorCount) - areaSize;

  // ----------------------------------------------------------------
  // per-sector decision
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < SectorCount; s++) begin : g_sector
      wire logic upperHit = AREA_W'(s) >= upperStart;
      wire logic lowerHit = AREA_W'(s) < areaSize;
      // bit 3 overrides both the direction and the low code bits
      assign sectorProtected[s] = protectCode[CODE_W-1] |
                                  (protectFromLowEnd ? lowerHit : upperHit);
    end
  endgenerate

endmodule

// File: tb/flash_write_protection_tb.sv
// Purpose: self-checking bench for the write-protection decision logic
// Assumes: decision answers on the taking edge and is read at the next falling edge
// Notes:   power-on wait shortened to 16 cycles
`timescale 1ns/1ps
module flash_write_protection_tb;
  import flash_protect_pkg::*;
  logic              ref_clk;
  logic              reset;
  logic              powerGood;
  logic [CODE_W-1:0] code;
  logic              fromLow;
  logic              cmdValid;
  cmd_req_t          cmdReq;
  logic              writeEnableLatch;
  logic              powerOnBusy;
  logic              decisionValid;
  decision_t         decision;
  int                errors;
  int                compares;

  spi_host_model host (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdReq(cmdReq));

  flash_write_protection #(.PorCycles(16)) uut (
    .ref_clk(ref_clk), .reset(reset), .powerGood(powerGood), .cmdValid(cmdValid),
    .cmdReq(cmdReq), .protect_code_bit3(code[3]), .protect_code_bit2(code[2]),
    .protect_code_bit1(code[1]), .protect_code_bit0(code[0]),
    .protect_from_low_end(fromLow), .writeEnableLatch(writeEnableLatch),
    .powerOnBusy(powerOnBusy), .decisionValid(decisionValid), .decision(decision)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic check1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_num(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  task automatic wait_ready;
    for (int i = 0; i < 200 && powerOnBusy !== 1'b0; i++) @(negedge ref_clk);
    if (powerOnBusy !== 1'b0) begin
      errors++;
      print_verdict();
    end
  endtask

  // reset or supply drop; either must wipe the volatile lock bits
  task automatic restart(input logic viaReset);
    reset = viaReset;
    powerGood = viaReset;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    powerGood = 1'b1;
    wait_ready();
  endtask

  task automatic wop(input cmd_kind_t k, input logic [23:0] a, input logic ld,
                     input logic wl, input logic expAllowed);
    host.modify(k, a, ld, wl);
    check1(decisionValid, 1'b1);
    check1(decision.allowed, expAllowed);
  endtask

  int n;
  int cand[6];

  initial begin
    reset = 1'b1;
    powerGood = 1'b1;
    code = 4'h0;
    fromLow = 1'b0;
    errors = 0;
    compares = 0;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    check1(powerOnBusy, 1'b1);
    wop(CMD_PAGE_PROG, 24'h00_1234, 1'b0, 1'b0, 1'b0);
    check1(decision.inPowerOn, 1'b1);
    wait_ready();
    host.send(CMD_WRITE_DIS, '0, 16'h0008, 1'b0, 1'b0);
    host.send(CMD_PAGE_PROG, 24'h00_1234, 16'h0810, 1'b0, 1'b0);
    check1(decision.noWriteEnable, 1'b1);
    check1(decision.allowed, 1'b0);
    host.send(CMD_WRITE_EN, '0, 16'h0008, 1'b0, 1'b0);
    check1(writeEnableLatch, 1'b1);
    host.send(CMD_PAGE_PROG, 24'h00_F123, 16'h0811, 1'b0, 1'b0);
    check1(decision.notAligned, 1'b1);
    check1(decision.allowed, 1'b0);
    host.send(CMD_STATUS_WRITE, '0, 16'h000F, 1'b0, 1'b0);
    check1(decision.notAligned, 1'b1);
    host.send(CMD_PAGE_PROG, 24'h00_F123, 16'h0810, 1'b0, 1'b0);
    check1(decision.allowed, 1'b1);
    check_num(16'(decision.subsector), 16'h000F);
    check1(writeEnableLatch, 1'b0);
    wop(CMD_SUBSEC_ERASE, 24'h7F_F000, 1'b0, 1'b0, 1'b1);
    check_num(16'(decision.sector), 16'h007F);
    check_num(16'(decision.subsector), 16'h07FF);
    wop(CMD_CONFIG_WRITE, '0, 1'b0, 1'b0, 1'b1);
    // every protect code from both ends, probed at the area boundaries
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 16; c++) begin
        code = c[3:0];
        fromLow = t[0];
        n = (c == 0) ? 0 : (c >= 8) ? 128 : (1 << (c - 1));
        cand = '{0, n - 1, n, 127 - n, 128 - n, 127};
        foreach (cand[i]) begin
          if (cand[i] >= 0 && cand[i] < 128) begin
            wop(CMD_SECTOR_ERASE, {1'b0, cand[i][6:0], 16'h4000}, 1'b0, 1'b0,
                t ? (cand[i] >= n) : (cand[i] < 128 - n));
            check1(decision.areaProtected,
                   t ? (cand[i] < n) : (cand[i] >= 128 - n));
          end
        end
      end
    end
    code = 4'h0;
    wop(CMD_LOCK_WRITE, 24'h05_0000, 1'b0, 1'b1, 1'b1);
    wop(CMD_SECTOR_ERASE, 24'h05_8000, 1'b0, 1'b0, 1'b0);
    check1(decision.sectorLocked, 1'b1);
    wop(CMD_SECTOR_ERASE, 24'h06_0000, 1'b0, 1'b0, 1'b1);
    wop(CMD_BULK_ERASE, '0, 1'b0, 1'b0, 1'b0);
    wop(CMD_LOCK_WRITE, 24'h05_0000, 1'b0, 1'b0, 1'b1);
    wop(CMD_PAGE_PROG, 24'h05_0100, 1'b0, 1'b0, 1'b1);
    wop(CMD_LOCK_WRITE, 24'h05_0000, 1'b1, 1'b1, 1'b1);
    wop(CMD_LOCK_WRITE, 24'h05_0000, 1'b0, 1'b0, 1'b0);
    check1(decision.lockDownHeld, 1'b1);
    wop(CMD_SUBSEC_ERASE, 24'h05_3000, 1'b0, 1'b0, 1'b0);
    restart(1'b1);
    wop(CMD_SUBSEC_ERASE, 24'h05_3000, 1'b0, 1'b0, 1'b1);
    wop(CMD_LOCK_WRITE, 24'h09_0000, 1'b1, 1'b1, 1'b1);
    restart(1'b0);
    wop(CMD_SECTOR_ERASE, 24'h09_0000, 1'b0, 1'b0, 1'b1);
    wop(CMD_BULK_ERASE, '0, 1'b0, 1'b0, 1'b1);
    check1(host.stalled, 1'b0);
    print_verdict();
  end
endmodule

// File: tb/spi_host_model.sv
// Purpose: host side that offers decoded commands to the protection logic
// Assumes: one command at a time, offered from a falling edge for one cycle
// Notes:   idle request fields toggle, so stale values are never trusted
`timescale 1ns/1ps
module spi_host_model
  import flash_protect_pkg::*;
(
  input  wire logic ref_clk,
  output logic      cmdValid,
  output cmd_req_t  cmdReq
);
  cmd_req_t pending[$];
  logic     stalled;

  initial begin
    cmdValid = 1'b0;
    cmdReq   = '0;
    stalled  = 1'b0;
  end

  // one driving process, so a queued request never races the idle pattern
  always @(negedge ref_clk) begin
    if (!cmdValid && pending.size() > 0) begin
      cmdValid <= 1'b1;
      cmdReq   <= pending.pop_front();
    end else begin
      cmdValid <= 1'b0;
      cmdReq   <= ~cmdReq;
    end
  end

  task automatic send(input cmd_kind_t k, input logic [ADDR_W-1:0] a,
                      input logic [PULSE_W-1:0] p, input logic ld, input logic wl);
    cmd_req_t req;
    req = '{kind: k, addr: a, pulseCount: p, lockDown: ld, writeLock: wl};
    pending.push_back(req);
    // bounded: a request not offered within eight cycles marks the host stalled
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      if (cmdValid && cmdReq == req) break;
    end
    if (!(cmdValid && cmdReq == req)) stalled = 1'b1;
  endtask

  // write enable always goes ahead of a modifying command
  task automatic modify(input cmd_kind_t k, input logic [ADDR_W-1:0] a,
                        input logic ld, input logic wl);
    send(CMD_WRITE_EN, '0, 16'h0008, 1'b0, 1'b0);
    send(k, a, 16'h0028, ld, wl);
  endtask
endmodule
